// ---- core/interrupt_vector_map.sv ----
`timescale 1ns/1ps

module interrupt_vector_map
   import vector_map_pkg::*;
#(
   parameter logic [ADDR_W-1:0] BOOT_ADDR = BOOT_ADDR_DEF
)(
   input  wire logic                 i_mclk,
   input  wire logic                 i_nrst,
   input  wire logic                 i_boot_reset_select_fuse,
   input  wire logic                 i_vector_table_select_bit,
   input  wire logic                 i_global_irq_enable,
   input  wire logic                 i_fetch_ready,
   input  wire logic                 i_external_request_zero,
   input  wire logic                 i_external_request_one,
   input  wire logic                 i_external_request_two,
   input  wire logic                 i_timer_two_compare_event,
   input  wire logic                 i_timer_two_overflow_event,
   input  wire logic                 i_timer_one_capture_event,
   input  wire logic                 i_timer_one_compare_a_event,
   input  wire logic                 i_timer_one_compare_b_event,
   input  wire logic                 i_timer_one_overflow_event,
   input  wire logic                 i_timer_zero_overflow_event,
   input  wire logic                 i_timer_zero_compare_event,
   input  wire logic                 i_serial_periph_transfer_done,
   input  wire logic                 i_uart_receive_done,
   input  wire logic                 i_uart_tx_buffer_empty,
   input  wire logic                 i_uart_transmit_done,
   input  wire logic                 i_converter_done,
   input  wire logic                 i_eeprom_write_ready,
   input  wire logic                 i_comparator_event,
   input  wire logic                 i_two_wire_serial_event,
   input  wire logic                 i_program_store_ready,
   output logic                      o_vector_valid,
   output logic [ADDR_W-1:0]         o_vector_addr,
   output logic                      o_vector_is_reset,
   output logic [IDX_W-1:0]          o_vector_number,
   output logic [NUM_SRC-1:0]        o_irq_ack
);

   // =====================================================================
   // Request gathering in vector-number order
   // =====================================================================
   logic [NUM_SRC-1:0]  req;
   logic [ADDR_W-1:0]   vec_table [NUM_SRC];
   logic                any_req;
   logic [IDX_W-1:0]    win_idx;

   // Bit k is vector number k+2
   // Sources run on this clock already, so no synchroniser is needed
   assign req = {
      i_program_store_ready,          // 21
      i_timer_zero_compare_event,     // 20
      i_external_request_two,         // 19
      i_two_wire_serial_event,        // 18
      i_comparator_event,             // 17
      i_eeprom_write_ready,           // 16
      i_converter_done,               // 15
      i_uart_transmit_done,           // 14
      i_uart_tx_buffer_empty,         // 13
      i_uart_receive_done,            // 12
      i_serial_periph_transfer_done,  // 11
      i_timer_zero_overflow_event,    // 10
      i_timer_one_overflow_event,     // 9
      i_timer_one_compare_b_event,    // 8
      i_timer_one_compare_a_event,    // 7
      i_timer_one_capture_event,      // 6
      i_timer_two_overflow_event,     // 5
      i_timer_two_compare_event,      // 4
      i_external_request_one,         // 3
      i_external_request_zero         // 2
   };

   // Fixed default table, one entry per source
   assign vec_table[0]  = VEC_EXT0;
   assign vec_table[1]  = VEC_EXT1;
   assign vec_table[2]  = VEC_T2_CMP;
   assign vec_table[3]  = VEC_T2_OVF;
   assign vec_table[4]  = VEC_T1_CAP;
   assign vec_table[5]  = VEC_T1_CMPA;
   assign vec_table[6]  = VEC_T1_CMPB;
   assign vec_table[7]  = VEC_T1_OVF;
   assign vec_table[8]  = VEC_T0_OVF;
   assign vec_table[9]  = VEC_SPI_DONE;
   assign vec_table[10] = VEC_RX_DONE;
   assign vec_table[11] = VEC_TX_EMPTY;
   assign vec_table[12] = VEC_TX_DONE;
   assign vec_table[13] = VEC_CONV;
   assign vec_table[14] = VEC_EEPROM_WRITE_READY;
   assign vec_table[15] = VEC_COMP;
   assign vec_table[16] = VEC_TWO_WIRE;
   assign vec_table[17] = VEC_EXT2;
   assign vec_table[18] = VEC_T0_CMP;
   assign vec_table[19] = VEC_STORE;

   vector_priority #(
      .N      (NUM_SRC)
   ) u_pick (
      .i_req  (req),
      .o_any  (any_req),
      .o_idx  (win_idx)
   );

   // =====================================================================
   // Address formation
   // =====================================================================
   logic [ADDR_W-1:0] reset_target;
   logic [ADDR_W-1:0] irq_target;

   // Fuse low means programmed, so reset goes to the boot loader
   assign reset_target = (i_boot_reset_select_fuse == FUSE_PROGRAMMED)
                         ? BOOT_ADDR : RESET_ADDR;
   // Whole table slides up by the boot base when selected
   assign irq_target = i_vector_table_select_bit
                       ? ADDR_W'(vec_table[win_idx] + BOOT_ADDR)
                       : vec_table[win_idx];

   // =====================================================================
   // Fetch sequencing
   // =====================================================================
   fetch_state_t state_r;
   logic         take;

   // Interrupt taken only when enabled, pending and core is idle
   // A request raised while a vector is pending simply waits its turn
   assign take = (state_r == ST_IDLE) && i_global_irq_enable
                 && any_req;

   // Reset fetch first, then one vector per taken interrupt
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         state_r <= ST_RESET_FETCH;
      else
      begin
         case (state_r)
            ST_RESET_FETCH:
               if (i_fetch_ready)
                  state_r <= ST_IDLE;
            ST_IDLE:
               if (take)
                  state_r <= ST_VECTOR;
            ST_VECTOR:
               if (i_fetch_ready)
                  state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // =====================================================================
   // Output registers
   // =====================================================================

   // Vector address is held while valid stands; during the reset fetch it reloads from the fuse each cycle
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_vector_addr <= RESET_ADDR;
      else if (state_r == ST_RESET_FETCH)
         o_vector_addr <= reset_target;
      else if (take)
         o_vector_addr <= irq_target;
   end

   // Number of the last taken vector; the reset fetch leaves it alone
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_vector_number <= '0;
      else if (take)
         o_vector_number <= IDX_W'(win_idx + 5'h02);
   end

   // Reset flag stands until the first taken interrupt
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_vector_is_reset <= 1'b1;
      else if (state_r == ST_RESET_FETCH)
         o_vector_is_reset <= 1'b1;
      else if (take)
         o_vector_is_reset <= 1'b0;
   end

   // =====================================================================
   // Source acknowledge
   // =====================================================================

   // One-cycle pulse to the winner so a level request can clear itself;
   // a source that ignores it is simply taken again
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_irq_ack <= '0;
      else
      begin
         o_irq_ack <= '0;
         if (take)
            o_irq_ack[win_idx] <= 1'b1;
      end
   end

   // =====================================================================
   // Fetch handshake
   // =====================================================================

   // Valid is combinational from the state, so it drops on the accept edge
   assign o_vector_valid = (state_r != ST_IDLE);

endmodule : interrupt_vector_map

// ---- pkg/vector_map_pkg.sv ----
package vector_map_pkg;

   // =====================================================================
   // Address widths and table geometry
   // =====================================================================
   localparam int          ADDR_W       = 13;
   localparam int          NUM_SRC      = 20;
   localparam int          IDX_W        = 5;
   localparam logic [12:0] RESET_ADDR   = 13'h0000;
   localparam logic [12:0] BOOT_ADDR_DEF = 13'h1C00;
   localparam logic [12:0] VEC_STEP     = 13'h0002;
   localparam logic        FUSE_PROGRAMMED = 1'b0;

   // =====================================================================
   // Default vector addresses, index 0 is vector number 2
   // =====================================================================
   localparam logic [12:0] VEC_EXT0     = 13'h0002;
   localparam logic [12:0] VEC_EXT1     = 13'h0004;
   localparam logic [12:0] VEC_T2_CMP   = 13'h0006;
   localparam logic [12:0] VEC_T2_OVF   = 13'h0008;
   localparam logic [12:0] VEC_T1_CAP   = 13'h000A;
   localparam logic [12:0] VEC_T1_CMPA  = 13'h000C;
   localparam logic [12:0] VEC_T1_CMPB  = 13'h000E;
   localparam logic [12:0] VEC_T1_OVF   = 13'h0010;
   localparam logic [12:0] VEC_T0_OVF   = 13'h0012;
   localparam logic [12:0] VEC_SPI_DONE = 13'h0014;
   localparam logic [12:0] VEC_RX_DONE  = 13'h0016;
   localparam logic [12:0] VEC_TX_EMPTY = 13'h0018;
   localparam logic [12:0] VEC_TX_DONE  = 13'h001A;
   localparam logic [12:0] VEC_CONV     = 13'h001C;
   localparam logic [12:0] VEC_EEPROM_WRITE_READY   = 13'h001E;
   localparam logic [12:0] VEC_COMP     = 13'h0020;
   localparam logic [12:0] VEC_TWO_WIRE = 13'h0022;
   localparam logic [12:0] VEC_EXT2     = 13'h0024;
   localparam logic [12:0] VEC_T0_CMP   = 13'h0026;
   localparam logic [12:0] VEC_STORE    = 13'h0028;

   typedef enum logic [1:0] {
      ST_RESET_FETCH,
      ST_IDLE,
      ST_VECTOR
   } fetch_state_t;

endpackage : vector_map_pkg

// ---- core/vector_priority.sv ----
`timescale 1ns/1ps

// =====================================================================
// Fixed priority pick, lowest index wins
// =====================================================================
module vector_priority
   import vector_map_pkg::*;
#(
   parameter int N = NUM_SRC
)(
   input  wire logic [N-1:0]     i_req,
   output logic                  o_any,
   output logic [IDX_W-1:0]      o_idx
);

   // Scan from the top so the lowest set bit is kept last
   always_comb
   begin
      o_any = 1'b0;
      o_idx = '0;
      for (int k = N - 1; k >= 0; k--)
      begin
         if (i_req[k])
         begin
            o_any = 1'b1;
            o_idx = IDX_W'(k);
         end
      end
   end

endmodule : vector_priority

// ---- sim/interrupt_vector_map_checker.sv ----
`timescale 1ns/1ps

// =====================================================================
// Port checker for the vector map
module interrupt_vector_map_checker
   import vector_map_pkg::*;
#(
   parameter logic [ADDR_W-1:0] BOOT_ADDR = BOOT_ADDR_DEF
)(
   input wire logic               i_mclk,
   input wire logic               i_nrst,
   input wire logic               i_boot_reset_select_fuse,
   input wire logic               i_vector_table_select_bit,
   input wire logic               i_global_irq_enable,
   input wire logic               i_fetch_ready,
   input wire logic               o_vector_valid,
   input wire logic [ADDR_W-1:0]  o_vector_addr,
   input wire logic               o_vector_is_reset,
   input wire logic [IDX_W-1:0]   o_vector_number,
   input wire logic [NUM_SRC-1:0] o_irq_ack
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   // Steps of a taken vector
   sequence s_ack;
      o_irq_ack != '0;
   endsequence
   sequence s_accept;
      o_vector_valid && i_fetch_ready;
   endsequence

   AST_ACK_CAUSE: assert property (s_ack |-> !$past(o_vector_valid)
      && $past(i_global_irq_enable)) else $error("ack without a take");
   AST_ONEHOT: assert property (s_ack |-> $onehot(o_irq_ack)
      && o_vector_valid && !o_vector_is_reset) else $error("ack not one-hot");
   AST_NUMBER: assert property (s_ack |->
      o_irq_ack == (20'h1 << (o_vector_number - 5'd2)))
      else $error("ack and number disagree");
   AST_ADDR: assert property (s_ack |-> o_vector_addr ==
      {7'h0, o_vector_number - 5'd1, 1'b0}
      + ($past(i_vector_table_select_bit) ? BOOT_ADDR : 13'h0))
      else $error("vector address wrong");
   AST_PULSE: assert property (s_ack |=> o_irq_ack == '0)
      else $error("ack longer than one cycle");
   AST_RESET_TARGET: assert property ($rose(i_nrst) |-> o_vector_valid
      ##1 o_vector_is_reset && o_vector_addr ==
      ((i_boot_reset_select_fuse == FUSE_PROGRAMMED) ? BOOT_ADDR : RESET_ADDR))
      else $error("reset target wrong");
   AST_HOLD: assert property (o_vector_valid && !i_fetch_ready
      && !o_vector_is_reset |=> o_vector_valid && $stable(o_vector_addr))
      else $error("vector dropped before fetch");
   AST_RELEASE: assert property (s_accept |=> !o_vector_valid)
      else $error("vector held after fetch");
   AST_REFUSE: assert property (!i_global_irq_enable |=> o_irq_ack == '0)
      else $error("ack while disabled");
endmodule : interrupt_vector_map_checker

bind interrupt_vector_map interrupt_vector_map_checker
   #(.BOOT_ADDR(BOOT_ADDR)) i_interrupt_vector_map_checker (.i_mclk, .i_nrst,
   .i_boot_reset_select_fuse, .i_vector_table_select_bit,
   .i_global_irq_enable, .i_fetch_ready, .o_vector_valid, .o_vector_addr,
   .o_vector_is_reset, .o_vector_number, .o_irq_ack);

// ---- sim/fetch_model.sv ----
`timescale 1ns/1ps

// =====================================================================
// Core fetch model, accepts a vector after a chosen wait
module fetch_model (
   input  wire logic       i_mclk,
   input  wire logic       i_nrst,
   input  wire logic       i_vector_valid,
   input  wire logic [2:0] i_wait,
   output logic            o_fetch_ready
);
   logic [2:0] cnt_r;
   logic       waiting;

   assign waiting = i_vector_valid && !o_fetch_ready;

   // One-cycle strobe, so a vector is never fetched twice
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_fetch_ready <= 1'b0;
         cnt_r         <= 3'h0;
      end
      else
      begin
         o_fetch_ready <= waiting && cnt_r >= i_wait;
         cnt_r         <= (waiting && cnt_r < i_wait) ? cnt_r + 3'h1 : 3'h0;
      end
   end
endmodule : fetch_model

// ---- sim/interrupt_vector_map_bench.sv ----
`timescale 1ns/1ps

// =====================================================================
// Vector map bench
module interrupt_vector_map_bench;
   import vector_map_pkg::*;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        fuse = 1'b1;
   logic        sel  = 1'b0;
   logic        en   = 1'b0;
   logic [19:0] req  = 20'h0;
   logic [2:0]  wt   = 3'h0;
   logic        ready, valid, is_rst;
   logic [19:0] ack;
   logic [12:0] addr;
   logic [4:0]  num;
   logic [17:0] e;
   logic [31:0] m;
   logic [17:0] expq[$];
   int          fails = 0;
   int          compares = 0;

   always #5 mclk = ~mclk;

   interrupt_vector_map i_interrupt_vector_map (.i_mclk(mclk), .i_nrst(nrst),
      .i_boot_reset_select_fuse(fuse), .i_vector_table_select_bit(sel),
      .i_global_irq_enable(en), .i_fetch_ready(ready),
      .i_external_request_zero(req[0]), .i_external_request_one(req[1]),
      .i_timer_two_compare_event(req[2]), .i_timer_two_overflow_event(req[3]),
      .i_timer_one_capture_event(req[4]), .i_timer_one_compare_a_event(req[5]),
      .i_timer_one_compare_b_event(req[6]),
      .i_timer_one_overflow_event(req[7]),
      .i_timer_zero_overflow_event(req[8]),
      .i_serial_periph_transfer_done(req[9]), .i_uart_receive_done(req[10]),
      .i_uart_tx_buffer_empty(req[11]), .i_uart_transmit_done(req[12]),
      .i_converter_done(req[13]), .i_eeprom_write_ready(req[14]),
      .i_comparator_event(req[15]), .i_two_wire_serial_event(req[16]),
      .i_external_request_two(req[17]), .i_timer_zero_compare_event(req[18]),
      .i_program_store_ready(req[19]), .o_vector_valid(valid),
      .o_vector_addr(addr), .o_vector_is_reset(is_rst),
      .o_vector_number(num), .o_irq_ack(ack));

   fetch_model i_fetch_model (.i_mclk(mclk), .i_nrst(nrst),
      .i_vector_valid(valid), .i_wait(wt), .o_fetch_ready(ready));

   task check(input string nm, input logic [19:0] seen, input logic [19:0] ex);
      compares++;
      if (seen !== ex)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check

   task end_sim;
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // Reset with a given fuse, then look at the reset fetch
   task do_reset(input logic f);
      // Let a standing ack be seen before reset wipes it
      if (nrst === 1'b1)
      begin
         repeat (2) @(posedge mclk);
         #1;
      end
      fuse = f;
      nrst = 1'b0;
      req  = 20'h0;
      en   = 1'b0;
      repeat (5) @(posedge mclk);
      #1 nrst = 1'b1;
      @(posedge mclk);
      #1;
      check("reset_addr", addr, f ? RESET_ADDR : BOOT_ADDR_DEF);
      check("reset_flag", {valid, is_rst, num}, 7'h60);
   endtask : do_reset

   // Note every requested vector lowest first, drop each source on its ack
   task run(input logic [19:0] mk);
      int n;
      for (int k = 0; k < 20; k++)
         if (mk[k])
            expq.push_back({13'((k + 1) * 2) + (sel ? BOOT_ADDR_DEF : 13'h0),
                            5'(k + 2)});
      wt  = 3'($urandom_range(7, 0));
      req = mk;
      en  = 1'b1;
      n   = 0;
      while (req !== 20'h0 && n < 300)
      begin
         @(posedge mclk);
         #1;
         req = req & ~ack;
         n++;
      end
      check("run_done", req, 20'h0);
   endtask : run

   // Each ack pulse retires the oldest note, looked at mid-cycle
   always @(negedge mclk)
      if (nrst === 1'b1 && ack !== 20'h0)
      begin
         if (expq.size() == 0)
            check("unexpected_ack", ack, 20'h0);
         else
         begin
            e = expq.pop_front();
            check("vector_addr", addr, e[17:5]);
            check("vector_num", num, e[4:0]);
            check("vector_flag", {valid, is_rst}, 2'b10);
         end
      end

   // Every source alone under both fuse settings, table select set to source index parity XOR fuse
   initial
   begin
      m = $urandom(32'hAFC5);
      for (int f = 0; f < 2; f++)
      begin
         do_reset(f[0]);
         for (int i = 0; i < 20; i++)
         begin
            sel = i[0] ^ f[0];
            run(20'h1 << i);
         end
      end
      // Requests held while disabled, then released together
      for (int i = 0; i < 30; i++)
      begin
         m   = $urandom;
         sel = m[20];
         en  = 1'b0;
         req = m[19:0];
         repeat (8) @(posedge mclk);
         #1;
         run(m[19:0]);
      end
      repeat (20) @(posedge mclk);
      check("queue_empty", 20'(expq.size()), 20'h0);
      end_sim();
   end

   // Hang guard, well past the expected run length
   initial
   begin
      #500us;
      fails++;
      end_sim();
   end
endmodule : interrupt_vector_map_bench
